// *** shared/stid_pkg.sv ***
package stid_pkg;

	// ****************************************************************
	// instruction codes, msb on the left
	// ****************************************************************
	localparam int IR_W = 3;
	typedef logic [IR_W-1:0] stid_ir_t;

	localparam stid_ir_t IR_EXTEST = 3'h0; // sample ring, data pins released
	localparam stid_ir_t IR_IDCODE = 3'h1; // default after power-up and reset state
	localparam stid_ir_t IR_SAMPLEZ = 3'h2; // sample ring, data pins released
	localparam stid_ir_t IR_SAMPLE = 3'h4; // sample only, no preload path
	localparam stid_ir_t IR_BYPASS = 3'h7;
	localparam stid_ir_t IR_RSV_A = 3'h3; // reserved_instruction codes
	localparam stid_ir_t IR_RSV_B = 3'h5;
	localparam stid_ir_t IR_RSV_C = 3'h6;

	// value loaded in capture-IR: low two bits are 01
	localparam stid_ir_t IR_CAPTURE = 3'h1;

	// ****************************************************************
	// data register sizes and fixed values
	// ****************************************************************
	localparam int ID_W = 32;
	// arbitrary identification value; bit 0 set as the scan convention wants
	localparam logic [ID_W-1:0] ID_VALUE_DEF = 32'h0A5A_0001;
	localparam int BSR_LEN_DEF = 8;
	localparam logic BYP_CAPTURE = 1'h0;

	// ****************************************************************
	// test controller states
	// ****************************************************************
	typedef enum logic [3:0] {
		ST_TLR = 4'hF,
		ST_RTI = 4'hC,
		ST_SEL_DR = 4'h7,
		ST_CAP_DR = 4'h6,
		ST_SH_DR = 4'h2,
		ST_EX1_DR = 4'h1,
		ST_PA_DR = 4'h3,
		ST_EX2_DR = 4'h0,
		ST_UPD_DR = 4'h5,
		ST_SEL_IR = 4'h4,
		ST_CAP_IR = 4'hE,
		ST_SH_IR = 4'hA,
		ST_EX1_IR = 4'h9,
		ST_PA_IR = 4'hB,
		ST_EX2_IR = 4'h8,
		ST_UPD_IR = 4'hD
	} stid_tap_state_t;

endpackage : stid_pkg

// *** shared/stid_tap_if.sv ***
`timescale 1ns/1ps
// state strobes from the controller to the decoder, all in the test clock domain
interface stid_tap_if;
	logic tlr;
	logic capture_ir;
	logic shift_ir;
	logic update_ir;
	logic capture_dr;
	logic shift_dr;
	logic update_dr;

	modport fsm (
		output tlr,
		output capture_ir,
		output shift_ir,
		output update_ir,
		output capture_dr,
		output shift_dr,
		output update_dr
	);
	modport dec (
		input tlr,
		input capture_ir,
		input shift_ir,
		input update_ir,
		input capture_dr,
		input shift_dr,
		input update_dr
	);
endinterface : stid_tap_if

// *** rtl/stid_tap_fsm.sv ***
`timescale 1ns/1ps
module stid_tap_fsm (
	input wire logic tck_i,
	input wire logic rstn_i,
	input wire logic tms_i,
	stid_tap_if.fsm tap
);
	import stid_pkg::*;

	typedef struct packed {
		stid_tap_state_t st;
	} stid_fsm_st_t;

	stid_fsm_st_t q_r;
	stid_fsm_st_t q_nxt;

	// ****************************************************************
	// next state from the mode-select level at each rising edge
	// ****************************************************************
	always_comb
	begin
		q_nxt = q_r;
		case (q_r.st)
			ST_TLR: q_nxt.st = tms_i ? ST_TLR : ST_RTI;
			ST_RTI: q_nxt.st = tms_i ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: q_nxt.st = tms_i ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: q_nxt.st = tms_i ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: q_nxt.st = tms_i ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: q_nxt.st = tms_i ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR: q_nxt.st = tms_i ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: q_nxt.st = tms_i ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: q_nxt.st = tms_i ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: q_nxt.st = tms_i ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: q_nxt.st = tms_i ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: q_nxt.st = tms_i ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: q_nxt.st = tms_i ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR: q_nxt.st = tms_i ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: q_nxt.st = tms_i ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: q_nxt.st = tms_i ? ST_SEL_DR : ST_RTI;
			default: q_nxt.st = ST_TLR;
		endcase
	end

	// power-up lands in the reset state, so the default instruction follows
	always_ff @(posedge tck_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q_r <= '{st: ST_TLR};
		else
			q_r <= q_nxt;
	end

	// state strobes for the decoder
	assign tap.tlr = (q_r.st == ST_TLR);
	assign tap.capture_ir = (q_r.st == ST_CAP_IR);
	assign tap.shift_ir = (q_r.st == ST_SH_IR);
	assign tap.update_ir = (q_r.st == ST_UPD_IR);
	assign tap.capture_dr = (q_r.st == ST_CAP_DR);
	assign tap.shift_dr = (q_r.st == ST_SH_DR);
	assign tap.update_dr = (q_r.st == ST_UPD_DR);

	// five edges with mode-select high always reach the reset state
	a_tms_reset_walk: assert property (
		@(posedge tck_i) disable iff (!rstn_i)
		tms_i [*5] |=> (q_r.st == ST_TLR))
		else $error("five high mode-select edges did not reach reset state");

endmodule : stid_tap_fsm

// *** rtl/stid_scan_tap.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - three-bit instruction, msb left, lsb shifted first
// - 000/010: boundary register selected, data pins released
// - 000/100/010: capture ring into boundary register
// - 001: load fixed id, select id register
// - 001 active at power-up and reset state
// - 100 samples only, never drives pins
// - 111: single-stage bypass between serial in/out
// - 001/100/111 leave memory and pins alone
// - state advances on mode-select at rising edge
// - capture-IR loads 01 into low bits
// - new instruction active only after update-IR
// - 100 update-DR acts like a pause
module stid_scan_tap #(
	parameter int BSR_LEN = stid_pkg::BSR_LEN_DEF,
	parameter logic [stid_pkg::ID_W-1:0] ID_VALUE = stid_pkg::ID_VALUE_DEF
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire logic [BSR_LEN-1:0] ring_pins_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	output logic dq_hiz_o,
	output stid_pkg::stid_ir_t active_instr_o
);
	import stid_pkg::*;

	// ****************************************************************
	// controller
	// ****************************************************************
	stid_tap_if tap ();

	stid_tap_fsm u_fsm (
		.tck_i(tck_i),
		.rstn_i(rstn_i),
		.tms_i(tms_i),
		.tap(tap.fsm)
	);

	// ****************************************************************
	// test clock domain state
	// ****************************************************************
	typedef struct packed {
		stid_ir_t ir_sh;
		stid_ir_t ir_act;
		logic [BSR_LEN-1:0] ring_s1;
		logic [BSR_LEN-1:0] ring_s2;
		logic [BSR_LEN-1:0] bsr;
		logic [ID_W-1:0] idr;
		logic byp;
		logic hz;
		logic tdo;
		logic tdo_oe;
	} stid_lnk_st_t;

	stid_lnk_st_t lq_r;
	stid_lnk_st_t lq_nxt;

	// register selection follows the active instruction only
	logic sel_bsr;
	logic sel_id;

	// boundary register for the sampling codes, id for 001, bypass otherwise
	always_comb
	begin
		sel_bsr = (lq_r.ir_act == IR_EXTEST) || (lq_r.ir_act == IR_SAMPLEZ) ||
			(lq_r.ir_act == IR_SAMPLE);
		sel_id = (lq_r.ir_act == IR_IDCODE);
	end

	// next value of the test clock domain
	always_comb
	begin
		lq_nxt = lq_r;
		// ring pins change with the memory clock, so they are synchronised first;
		// a ring still moving at capture gives an unrepeatable but harmless sample
		lq_nxt.ring_s1 = ring_pins_i;
		lq_nxt.ring_s2 = lq_r.ring_s1;

		// instruction path: capture pattern, shift lsb first, take on update
		if (tap.capture_ir)
			lq_nxt.ir_sh = IR_CAPTURE;
		else if (tap.shift_ir)
			lq_nxt.ir_sh = {tdi_i, lq_r.ir_sh[IR_W-1:1]};
		if (tap.tlr)
			lq_nxt.ir_act = IR_IDCODE;
		else if (tap.update_ir)
			lq_nxt.ir_act = lq_r.ir_sh;

		// data path capture and shift
		if (tap.capture_dr)
		begin
			if (sel_bsr)
				lq_nxt.bsr = lq_r.ring_s2;
			else if (sel_id)
				lq_nxt.idr = ID_VALUE;
			else
				lq_nxt.byp = BYP_CAPTURE;
		end
		else if (tap.shift_dr)
		begin
			if (sel_bsr)
				lq_nxt.bsr = {tdi_i, lq_r.bsr[BSR_LEN-1:1]};
			else if (sel_id)
				lq_nxt.idr = {tdi_i, lq_r.idr[ID_W-1:1]};
			else
				lq_nxt.byp = tdi_i;
		end
		// update-DR has no preload stage anywhere, so it changes nothing

		// serial output follows the register in the shift state
		lq_nxt.tdo_oe = tap.shift_ir || tap.shift_dr;
		if (tap.shift_ir)
			lq_nxt.tdo = lq_r.ir_sh[0];
		else if (tap.shift_dr)
		begin
			if (sel_bsr)
				lq_nxt.tdo = lq_r.bsr[0];
			else if (sel_id)
				lq_nxt.tdo = lq_r.idr[0];
			else
				lq_nxt.tdo = lq_r.byp;
		end

		// pin release only for the two high-impedance codes; all others,
		// reserved ones included, leave the drivers to the memory
		lq_nxt.hz = (lq_nxt.ir_act == IR_EXTEST) || (lq_nxt.ir_act == IR_SAMPLEZ);
	end

	// async reset gives the default instruction before the first test clock
	always_ff @(posedge tck_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			lq_r <= '0;
			lq_r.ir_sh <= IR_CAPTURE;
			lq_r.ir_act <= IR_IDCODE;
		end
		else
			lq_r <= lq_nxt;
	end

	// ****************************************************************
	// memory clock domain: pin release level crosses by three flops
	// ****************************************************************
	typedef struct packed {
		logic hz_s1;
		logic hz_s2;
		logic hz_out;
	} stid_sys_st_t;

	stid_sys_st_t sq_r;
	stid_sys_st_t sq_nxt;

	// clock enable freezes the whole memory side
	always_comb
	begin
		sq_nxt = sq_r;
		if (ce_i)
		begin
			sq_nxt.hz_s1 = lq_r.hz;
			sq_nxt.hz_s2 = sq_r.hz_s1;
			sq_nxt.hz_out = sq_r.hz_s2;
		end
	end

	// reset instruction is id, so the pins start driven
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			sq_r <= '0;
		else
			sq_r <= sq_nxt;
	end

	// outputs straight from flops
	assign tdo_o = lq_r.tdo;
	assign tdo_oe_o = lq_r.tdo_oe;
	assign active_instr_o = lq_r.ir_act;
	assign dq_hiz_o = sq_r.hz_out;

	// ****************************************************************
	// checks
	// ****************************************************************
	a_ir_lsb_first: assert property (
		@(posedge tck_i) disable iff (!rstn_i)
		tap.shift_ir |=> (tdo_o == $past(lq_r.ir_sh[0])) && tdo_oe_o)
		else $error("instruction bit shifted out is not the lsb");

	a_hiz_codes: assert property (
		@(posedge tck_i) disable iff (!rstn_i)
		((lq_r.ir_act == IR_EXTEST) || (lq_r.ir_act == IR_SAMPLEZ)) |-> lq_r.hz && sel_bsr)
		else $error("high-impedance code without pin release or ring select");

	a_ring_capture: assert property (
		@(posedge tck_i) disable iff (!rstn_i)
		(tap.capture_dr && sel_bsr) |=> (lq_r.bsr == $past(lq_r.ring_s2)))
		else $error("ring not captured into boundary register");

	a_id_load: assert property (
		@(posedge tck_i) disable iff (!rstn_i)
		(tap.capture_dr && lq_r.ir_act == IR_IDCODE) |=> (lq_r.idr == ID_VALUE))
		else $error("id register did not load fixed value");

	a_reset_idcode: assert property (
		@(posedge tck_i) disable iff (!rstn_i)
		tap.tlr |=> (active_instr_o == IR_IDCODE) && !lq_r.hz)
		else $error("reset state did not select id instruction");

	a_bypass_path: assert property (
		@(posedge tck_i) disable iff (!rstn_i)
		(tap.shift_dr && lq_r.ir_act == IR_BYPASS) ##1 tap.shift_dr
		|=> (tdo_o == $past(tdi_i, 2)))
		else $error("bypass is not a single stage");

	a_no_release: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		(!lq_r.hz && ce_i) [*3] |=> !dq_hiz_o)
		else $error("pins released while a non-release code is active");

	a_ir_held: assert property (
		@(posedge tck_i) disable iff (!rstn_i)
		(!tap.update_ir && !tap.tlr) |=> $stable(active_instr_o))
		else $error("active instruction changed outside update");

	a_sample_update: assert property (
		@(posedge tck_i) disable iff (!rstn_i)
		(tap.update_dr && lq_r.ir_act == IR_SAMPLE) |=> $stable(lq_r.bsr) && $stable(lq_r.hz))
		else $error("update with sample code changed state");

	a_rsv_bypass: assert property (
		@(posedge tck_i) disable iff (!rstn_i)
		(tap.shift_dr && ((lq_r.ir_act == IR_RSV_A) || (lq_r.ir_act == IR_RSV_B) ||
			(lq_r.ir_act == IR_RSV_C))) |=> (tdo_o == $past(lq_r.byp)) && !lq_r.hz)
		else $error("reserved code did not behave as bypass");

endmodule : stid_scan_tap

// *** test/stid_link_ctl.sv ***
`timescale 1ns/1ps
// board-side scan controller; the link clock runs only inside frames
module stid_link_ctl (
	input wire logic tdo_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	import stid_pkg::*;

	// link parked low between frames
	initial
	begin
		tck_o = 1'h0;
		tms_o = 1'h1;
		tdi_o = 1'h0;
	end

	// one link cycle: levels settle about half a period before the rise
	// the rise sits 1 ns off the memory clock grid so the two clocks never line up
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tms_o = tms;
		tdi_o = tdi;
		#31 tck_o = 1'h1;
		#4 tdo = tdo_i;
		#29 tck_o = 1'h0;
	endtask : step

	// non-shift edge: data line flips so a stale bit never looks valid
	task automatic idle(input logic tms);
		logic d;
		step(tms, ~tdi_o, d);
	endtask : idle

	// five high mode-select edges reach test-logic-reset, then park in idle
	task automatic tap_reset();
		repeat (5) idle(1'h1);
		idle(1'h0);
	endtask : tap_reset

	// capture then shift n bits lsb first, msb of the code last
	// stops in exit-1 so the caller can look before the update
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic b;
		dout = '0;
		idle(1'h1);
		if (ir)
			idle(1'h1);
		idle(1'h0);
		idle(1'h0);
		for (int i = 0; i < n; i++)
		begin
			step(logic'(i == n - 1), din[i], b);
			dout[i] = b;
		end
	endtask : scan

	// update then back to idle; codes come only from the bench
	task automatic finish();
		idle(1'h1);
		idle(1'h0);
	endtask : finish
endmodule : stid_link_ctl

// *** test/stid_scan_tap_test.sv ***
`timescale 1ns/1ps
module stid_scan_tap_test;
	import stid_pkg::*;

	logic mclk_i = 1'h0;
	logic rstn_i = 1'h1;
	logic ce_i = 1'h1;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	logic dq_hiz;
	logic [BSR_LEN_DEF-1:0] ring = '0;
	stid_ir_t act;
	int failures = 0;
	int checks = 0;

	// ****************************************************************
	// clock, design and link partner
	// ****************************************************************
	always #2 mclk_i = ~mclk_i;

	stid_scan_tap #(.BSR_LEN(BSR_LEN_DEF), .ID_VALUE(ID_VALUE_DEF)) i_dut (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .ring_pins_i(ring), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
		.dq_hiz_o(dq_hiz), .active_instr_o(act));

	stid_link_ctl i_link (.tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

	// ****************************************************************
	// checking helpers
	// ****************************************************************
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_ir(input stid_ir_t got, input stid_ir_t exp);
		cmp_word(32'(got), 32'(exp));
	endtask : cmp_ir

	// 32 shifted bits: boundary codes show the ring then tdi, bypass one stage late
	function automatic logic [31:0] exp_dr(stid_ir_t c, logic [BSR_LEN_DEF-1:0] r,
		logic [31:0] d);
		if (c == IR_IDCODE)
			return ID_VALUE_DEF;
		if (c == IR_EXTEST || c == IR_SAMPLEZ || c == IR_SAMPLE)
			return (d << BSR_LEN_DEF) | 32'(r);
		return d << 1;
	endfunction : exp_dr

	// only the two release codes float the data pins
	function automatic logic is_hiz(stid_ir_t c);
		return (c == IR_EXTEST) || (c == IR_SAMPLEZ);
	endfunction : is_hiz

	// random draws keep to legal codes; a reserved draw becomes bypass
	function automatic stid_ir_t pick_code();
		stid_ir_t c;
		c = stid_ir_t'($urandom);
		if (c == IR_RSV_A || c == IR_RSV_B || c == IR_RSV_C)
			c = IR_BYPASS;
		return c;
	endfunction : pick_code

	task automatic results();
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// ****************************************************************
	// tests: every code once, then random codes with resets among them
	// ****************************************************************
	initial
	begin
		stid_ir_t code;
		stid_ir_t cur;
		logic [31:0] din;
		logic [31:0] dout;
		void'($urandom(21));
		// a clean falling edge resets both domains before any clock edge
		#1 rstn_i = 1'h0;
		repeat (2) @(negedge mclk_i);
		rstn_i = 1'h1;
		cmp_ir(act, IR_IDCODE);
		cmp_word(32'(dq_hiz), 32'h0);
		i_link.idle(1'h0);
		cur = IR_IDCODE;
		for (int i = 0; i < 20; i++)
		begin
			// codes 0..7 by hand, reserved ones on purpose; random draws stay legal
			code = (i < 8) ? stid_ir_t'(i) : pick_code();
			din = $urandom;
			@(negedge mclk_i) ring = BSR_LEN_DEF'($urandom);
			i_link.scan(1'h1, 3, 32'(code), dout);
			cmp_word(dout, 32'(IR_CAPTURE));
			cmp_ir(act, cur);
			// some updates land while the memory side is frozen
			@(negedge mclk_i) ce_i = (i % 4 != 2);
			i_link.finish();
			cmp_ir(act, code);
			repeat (16) @(negedge mclk_i);
			cmp_word(32'(dq_hiz), 32'(is_hiz(ce_i ? code : cur)));
			ce_i = 1'h1;
			cur = code;
			// hiz crosses into the memory clock through a short sync chain
			repeat (16) @(negedge mclk_i);
			cmp_word(32'(dq_hiz), 32'(code == IR_EXTEST || code == IR_SAMPLEZ));
			i_link.scan(1'h0, 32, din, dout);
			i_link.finish();
			cmp_word(dout, exp_dr(code, ring, din));
			repeat (16) @(negedge mclk_i);
			cmp_word(32'(dq_hiz), 32'(code == IR_EXTEST || code == IR_SAMPLEZ));
			cmp_ir(act, code);
			cmp_word(32'(tdo_oe), 32'h0);
			if (i % 5 == 4)
			begin
				i_link.tap_reset();
				cur = IR_IDCODE;
				cmp_ir(act, IR_IDCODE);
			end
		end
		results();
	end

	// hang guard, several times the expected run
	initial
	begin
		#200000;
		failures++;
		results();
	end
endmodule : stid_scan_tap_test
